// >>> brpp_pkg.sv
// Package of constants and types for the remote digit-pair programming port.
package brpp_pkg;
    // Register offsets on the APB side (byte addresses).
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_IRQ     = 8'h08;
    localparam logic [7:0] OFF_MASK    = 8'h0c;
    localparam logic [7:0] OFF_TEMP_LO = 8'h10;
    localparam logic [7:0] OFF_TEMP_HI = 8'h14;
    localparam logic [7:0] OFF_CF_LO   = 8'h18;
    localparam logic [7:0] OFF_CF_HI   = 8'h1c;
    localparam logic [7:0] OFF_STEP_LO = 8'h20;
    localparam logic [7:0] OFF_STEP_HI = 8'h24;
    localparam logic [7:0] OFF_ATTEN   = 8'h28;
    localparam logic [7:0] OFF_MODFN   = 8'h2c;
    localparam logic [7:0] OFF_MODPCT  = 8'h30;
    // Target register addresses carried in digit group two.
    localparam logic [3:0] ADR_CF     = 4'h0;
    localparam logic [3:0] ADR_STEP   = 4'h1;
    localparam logic [3:0] ADR_ATTEN  = 4'h3;
    localparam logic [3:0] ADR_MODFN  = 4'h4;
    localparam logic [3:0] ADR_MODPCT = 4'h5;
    // Group one value that marks a pair as an address.
    localparam logic [3:0] ADDR_MARK  = 4'hf;
    // Modulation type digit codes.
    localparam logic [3:0] TYPE_PM    = 4'hc;
    localparam logic [3:0] TYPE_FM_A  = 4'h4;
    localparam logic [3:0] TYPE_FM_B  = 4'h2;
    localparam logic [3:0] TYPE_FM_C  = 4'h1;
    localparam logic [3:0] TYPE_OFF   = 4'h0;
    localparam logic [3:0] TYPE_AM    = 4'h8;
    // Modulation source digit codes.
    localparam logic [3:0] SRC_EXT_AC = 4'h9;
    localparam logic [3:0] SRC_EXT_DC = 4'h4;
    localparam logic [3:0] SRC_I400   = 4'h2;
    localparam logic [3:0] SRC_I1K    = 4'h1;
    // Reference level of the attenuator in dBm.
    localparam int         ATTEN_REF_DBM = 13;
    // Reset pulse minimum and flag duration.
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         RST_MIN_NS    = 5000;
    localparam int         RST_CYC       = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int         FLAG_NS       = 1000;
    localparam int         FLAG_CYC      = (FLAG_NS * (CLK_HZ / 1_000_000)) / 1000;
    // Reset values.
    localparam logic [39:0] TEMP_RST     = 40'h00_0000_0000;
    localparam logic [7:0]  MASK_RST     = 8'h00;
    // Interrupt status bit positions.
    localparam int         IRQ_DATA  = 0;
    localparam int         IRQ_XFER  = 1;
    localparam int         IRQ_BADAD = 2;
    localparam int         IRQ_RRST  = 3;
    // Modulation type decode.
    typedef enum logic [2:0] {
        BRPP_MT_OFF  = 3'h0,
        BRPP_MT_AM   = 3'h1,
        BRPP_MT_FM1  = 3'h2,
        BRPP_MT_FM2  = 3'h3,
        BRPP_MT_FM3  = 3'h4,
        BRPP_MT_PM   = 3'h5,
        BRPP_MT_BAD  = 3'h7
    } brpp_mtype_t;
    // Modulation source decode.
    typedef enum logic [2:0] {
        BRPP_MS_NONE = 3'h0,
        BRPP_MS_EXTAC = 3'h1,
        BRPP_MS_EXTDC = 3'h2,
        BRPP_MS_I400 = 3'h3,
        BRPP_MS_I1K  = 3'h4,
        BRPP_MS_BAD  = 3'h7
    } brpp_msrc_t;
    // Pin bundle from the controller, already in positive logic.
    typedef struct packed {
        logic       strobe;
        logic [3:0] grp_one;
        logic [3:0] grp_two;
    } brpp_pins_t;
    // Decoded modulation setting.
    typedef struct packed {
        brpp_mtype_t mtype;
        brpp_msrc_t  msrc;
    } brpp_mod_t;
    // Strobe handshake states, Gray along idle, busy, hold.
    typedef enum logic [1:0] {
        BRPP_IDLE = 2'b00,
        BRPP_BUSY = 2'b01,
        BRPP_HOLD = 2'b11
    } brpp_state_t;
endpackage

// >>> brpp_port.sv
// Remote digit-pair programming port with APB register access.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Data strobe shifts new pair into temp
// [R2] Group one all ones marks address; transfer
// [R3] Attenuator keeps three most significant digits
// [R4] Attenuator value is dB below reference
// [R5] Zero transfer to function turns modulation off
// [R6] Function: high digit type, low source
// [R7] Decode type and source digit codes
// [R8] Percent register loads independently by address
// [R9] Step register keeps increment for stepping
// [R10] Lines are negative true, low means one
// [R11] Capture digits at strobe trailing edge
// [R12] Flag asserts acknowledging each strobe
// [R13] Remote reset reinitialises, five microsecond minimum
// [R14] Temp holds ten digits, overflow discarded
// [R15] Unknown address clears temp, changes nothing
module brpp_port
    import brpp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_strobe_n,
    input  wire logic [3:0]  digit_group_one_n,
    input  wire logic [3:0]  digit_group_two_n,
    input  wire logic        remote_reset_n,
    input  wire logic        local_remote_select_n,
    output logic             flag_n,
    output logic             irq
);
    // Controller lines turned into positive logic.
    brpp_pins_t  pins;
    // Strobe level of the previous cycle, for the trailing edge.
    logic        strobe_q;
    // Digit groups latched while the strobe is active.
    logic [3:0]  g1_q;
    logic [3:0]  g2_q;
    // One-cycle pulse on the strobe's trailing edge.
    logic        trail;
    // Ten-digit temporary register.
    logic [39:0] temp_q;
    // Pending address from the last address pair.
    logic        addr_pend_q;
    logic [3:0]  addr_q;
    // High when the pending address names a storage register that exists here.
    logic        known_adr;
    // Final storage registers.
    logic [39:0] centre_frequency_reg_q;
    logic [39:0] step_q;
    logic [11:0] atten_q;
    logic [7:0]  modfn_q;
    logic [39:0] modpct_q;
    // Flag state machine and its counter.
    brpp_state_t st_q;
    logic [7:0]  flag_cnt_q;
    // Remote reset length counter and the resulting pulse.
    logic [7:0]  rrst_cnt_q;
    logic        rrst_q;
    // Software control, interrupt status and mask.
    logic        sw_clear_q;
    logic [7:0]  irq_q;
    logic [7:0]  mask_q;
    logic [7:0]  irq_set;
    // Register bus decode.
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_d;
    logic        hit;
    // Decoded modulation state.
    brpp_mod_t   mod_dec;

    // Invert all lines: low on the pin means logical one. [R10]
    assign pins = '{strobe: ~cmd_strobe_n, grp_one: ~digit_group_one_n,
                    grp_two: ~digit_group_two_n};

    // Latch digits while the strobe is high; the controller holds them until it ends. [R11]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b0;
            g1_q     <= 4'h0;
            g2_q     <= 4'h0;
        end else begin
            strobe_q <= pins.strobe;
            if (pins.strobe) begin
                g1_q <= pins.grp_one;
                g2_q <= pins.grp_two;
            end
        end
    end

    // Act on the trailing edge, using the digits held during the strobe. [R11]
    assign trail = strobe_q & ~pins.strobe & local_remote_select_n == 1'b0;

    // Remote reset must stay asserted long enough before it counts. [R13]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rrst_cnt_q <= 8'h00;
            rrst_q     <= 1'b0;
        end else begin
            rrst_q <= 1'b0;
            if (remote_reset_n) begin
                rrst_cnt_q <= 8'h00;
            end else if (rrst_cnt_q < 8'(RST_CYC)) begin
                rrst_cnt_q <= rrst_cnt_q + 8'h01;
                rrst_q     <= (rrst_cnt_q == 8'(RST_CYC - 1));
            end
        end
    end

    // Temporary register and pending address. [R1] [R2] [R14]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_q      <= TEMP_RST;
            addr_pend_q <= 1'b0;
            addr_q      <= 4'h0;
        end else if (rrst_q || sw_clear_q) begin
            temp_q      <= TEMP_RST; // [R13]
            addr_pend_q <= 1'b0;
        end else if (trail) begin
            if (g1_q == ADDR_MARK) begin
                // Address pair: the next strobe transfers and clears. [R2]
                addr_pend_q <= 1'b1;
                addr_q      <= g2_q;
            end else if (addr_pend_q) begin
                // Transfer strobe always clears temp, even for unknown targets. [R2] [R15]
                temp_q      <= TEMP_RST;
                addr_pend_q <= 1'b0;
            end else begin
                // New pair enters at the top; the oldest pair falls off the bottom. [R1] [R14]
                temp_q <= {g2_q, g1_q, temp_q[39:8]};
            end
        end
    end

    // Final storage registers load on the transfer strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            centre_frequency_reg_q <= 40'h0;
            step_q                 <= 40'h0;
            atten_q                <= 12'h0;
            modfn_q                <= 8'h0;
            modpct_q               <= 40'h0;
        end else if (rrst_q) begin
            modfn_q <= 8'h0; // [R13]
        end else if (trail && addr_pend_q && g1_q != ADDR_MARK) begin
            case (addr_q)
                ADR_CF:     centre_frequency_reg_q <= temp_q;
                ADR_STEP:   step_q   <= temp_q; // [R9]
                ADR_ATTEN:  atten_q  <= temp_q[39:28]; // [R3]
                ADR_MODFN:  modfn_q  <= temp_q[39:32]; // [R5] [R6]
                ADR_MODPCT: modpct_q <= temp_q; // [R8]
                default:    ; // Unknown targets keep all storage. [R15]
            endcase
        end
    end

    // Decode type from the high digit, source from the low digit. [R6] [R7]
    always_comb begin
        case (modfn_q[7:4])
            TYPE_OFF:  mod_dec.mtype = BRPP_MT_OFF;
            TYPE_AM:   mod_dec.mtype = BRPP_MT_AM;
            TYPE_FM_A: mod_dec.mtype = BRPP_MT_FM1;
            TYPE_FM_B: mod_dec.mtype = BRPP_MT_FM2;
            TYPE_FM_C: mod_dec.mtype = BRPP_MT_FM3;
            TYPE_PM:   mod_dec.mtype = BRPP_MT_PM;
            default:   mod_dec.mtype = BRPP_MT_BAD;
        endcase
        case (modfn_q[3:0])
            4'h0:       mod_dec.msrc = BRPP_MS_NONE;
            SRC_EXT_AC: mod_dec.msrc = BRPP_MS_EXTAC;
            SRC_EXT_DC: mod_dec.msrc = BRPP_MS_EXTDC;
            SRC_I400:   mod_dec.msrc = BRPP_MS_I400;
            SRC_I1K:    mod_dec.msrc = BRPP_MS_I1K;
            default:    mod_dec.msrc = BRPP_MS_BAD;
        endcase
        // All-zero function means modulation off regardless of source. [R5]
        if (modfn_q == 8'h00) begin
            mod_dec.mtype = BRPP_MT_OFF;
        end
    end

    // Flag machine: busy from strobe start, held a fixed time after it ends. [R12]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= BRPP_IDLE;
            flag_cnt_q <= 8'h00;
        end else begin
            case (st_q)
                BRPP_IDLE: begin
                    if (pins.strobe) begin
                        st_q <= BRPP_BUSY;
                    end
                end
                BRPP_BUSY: begin
                    if (!pins.strobe) begin
                        st_q       <= BRPP_HOLD;
                        flag_cnt_q <= 8'(FLAG_CYC);
                    end
                end
                BRPP_HOLD: begin
                    if (flag_cnt_q == 8'h01) begin
                        st_q <= BRPP_IDLE;
                    end
                    flag_cnt_q <= flag_cnt_q - 8'h01;
                end
                default: st_q <= BRPP_IDLE;
            endcase
        end
    end

    // Flag is driven active low, busy in any state but idle. [R10] [R12]
    assign flag_n = (st_q == BRPP_IDLE);

    // Step down and every code above the percent register have no storage here. [R15]
    assign known_adr = (addr_q == ADR_CF) || (addr_q == ADR_STEP) || (addr_q == ADR_ATTEN) ||
                       (addr_q == ADR_MODFN) || (addr_q == ADR_MODPCT);

    // Events that raise sticky interrupt bits.
    assign irq_set = {4'h0, rrst_q,
                      trail && addr_pend_q && g1_q != ADDR_MARK && !known_adr,
                      trail && addr_pend_q && g1_q != ADDR_MARK,
                      trail && g1_q != ADDR_MARK && !addr_pend_q};

    // APB decode; slave is zero-wait.
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Control register: bit 0 clears the temporary register (self-clearing).
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_clear_q <= 1'b0;
            mask_q     <= MASK_RST;
        end else begin
            sw_clear_q <= wr_en && paddr == OFF_CTRL && pwdata[0];
            if (wr_en && paddr == OFF_MASK) begin
                mask_q <= pwdata[7:0];
            end
        end
    end

    // Sticky status, cleared by reading it; a set in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 8'h00;
        end else if (rd_en && paddr == OFF_IRQ) begin
            // Only the bits that the read returned are cleared, so a late event is kept.
            irq_q <= (irq_q & ~prdata[7:0]) | irq_set;
        end else begin
            irq_q <= irq_q | irq_set;
        end
    end

    assign irq = |(irq_q & mask_q);

    // Read mux.
    always_comb begin
        hit  = 1'b1;
        rd_d = 32'h0;
        case (paddr)
            OFF_CTRL:    rd_d = 32'h0;
            OFF_STATUS:  rd_d = {17'h0, mod_dec, st_q, 2'b0, addr_pend_q, addr_q};
            OFF_IRQ:     rd_d = {24'h0, irq_q};
            OFF_MASK:    rd_d = {24'h0, mask_q};
            OFF_TEMP_LO: rd_d = temp_q[31:0];
            OFF_TEMP_HI: rd_d = {24'h0, temp_q[39:32]};
            OFF_CF_LO:   rd_d = centre_frequency_reg_q[31:0];
            OFF_CF_HI:   rd_d = {24'h0, centre_frequency_reg_q[39:32]};
            OFF_STEP_LO: rd_d = step_q[31:0];
            OFF_STEP_HI: rd_d = {24'h0, step_q[39:32]};
            OFF_ATTEN:   rd_d = {20'h0, atten_q}; // [R4]
            OFF_MODFN:   rd_d = {24'h0, modfn_q};
            // Percent digits enter at the top, so the upper eight digits are shown.
            OFF_MODPCT:  rd_d = modpct_q[39:8];
            default:     hit = 1'b0;
        endcase
    end

    // Read data from a flop, loaded in the setup phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // Assertions.
    AST_SHIFT: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        trail && g1_q != ADDR_MARK && !addr_pend_q && !rrst_q && !sw_clear_q
        |=> temp_q == {$past(g2_q), $past(g1_q), $past(temp_q[39:8])})
        else $error("temp shift wrong");
    AST_XFER_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        trail && addr_pend_q && g1_q != ADDR_MARK |=> temp_q == 40'h0 && !addr_pend_q)
        else $error("transfer did not clear temp");
    AST_ATTEN: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        trail && addr_pend_q && g1_q != ADDR_MARK && addr_q == ADR_ATTEN && !rrst_q
        |=> atten_q == $past(temp_q[39:28]))
        else $error("attenuator truncation wrong");
    AST_MODOFF: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        modfn_q == 8'h00 |-> mod_dec.mtype == BRPP_MT_OFF)
        else $error("zero function not off");
    AST_AM1K: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        modfn_q == 8'h81 |-> mod_dec.mtype == BRPP_MT_AM && mod_dec.msrc == BRPP_MS_I1K)
        else $error("function decode wrong");
    AST_PCT: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        trail && addr_pend_q && g1_q != ADDR_MARK && addr_q == ADR_MODPCT && !rrst_q
        |=> modpct_q == $past(temp_q) && $stable(modfn_q))
        else $error("percent load wrong");
    AST_BADADR: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        trail && addr_pend_q && g1_q != ADDR_MARK && !known_adr && !rrst_q
        |=> $stable(centre_frequency_reg_q) && $stable(step_q) && $stable(atten_q)
            && $stable(modfn_q) && $stable(modpct_q))
        else $error("unknown address changed storage");
    AST_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        st_q == BRPP_IDLE && pins.strobe |=> !flag_n ##1 !flag_n)
        else $error("flag not raised on strobe");
    AST_RRST: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        rrst_q |=> temp_q == 40'h0 && modfn_q == 8'h00)
        else $error("remote reset did not clear");
    AST_STEP: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        trail && addr_pend_q && g1_q != ADDR_MARK && addr_q == ADR_STEP && !rrst_q
        |=> step_q == $past(temp_q))
        else $error("step load wrong");
    AST_MODFN: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        trail && addr_pend_q && g1_q != ADDR_MARK && addr_q == ADR_MODFN && !rrst_q
        |=> modfn_q == $past(temp_q[39:32]) && $stable(modpct_q))
        else $error("function load wrong");
    // A status read may only clear bits that it returned.
    AST_IRQ_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == OFF_IRQ
        |=> ($past(irq_q) & ~$past(prdata[7:0]) & ~irq_q) == 8'h00)
        else $error("unreported status bit lost");
endmodule
`default_nettype wire

// >>> brpp_ctl_model.sv
// Behavioural model of the remote controller that drives digit pairs and strobes.
`timescale 1ns/1ps
`default_nettype none
module brpp_ctl_model (
    input  wire logic       pclk,
    input  wire logic       flag_n,
    output logic            cmd_strobe_n,
    output logic [3:0]      digit_group_one_n,
    output logic [3:0]      digit_group_two_n
);
    // Lines start idle; undriven digits carry a pattern, not a clean zero.
    initial begin
        cmd_strobe_n      = 1'b1;
        digit_group_one_n = 4'h5;
        digit_group_two_n = 4'ha;
    end

    // One strobe of hold cycles; ok reports that the busy flag acknowledged it.
    task automatic send(input logic [3:0] g1, input logic [3:0] g2, input int hold,
                        output logic ok);
        int n;
        @(posedge pclk);
        cmd_strobe_n      <= 1'b0;
        digit_group_one_n <= ~g1;
        digit_group_two_n <= ~g2;
        repeat (hold) @(posedge pclk);
        ok = (flag_n === 1'b0);
        cmd_strobe_n      <= 1'b1;
        @(posedge pclk);
        // Released lines flip so that a late capture shows up as a wrong digit.
        digit_group_one_n <= g1;
        digit_group_two_n <= g2;
        n = 0;
        // The flag must still be up after the trailing edge and drop in time.
        while (flag_n !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        ok = ok && (n > 0) && (n < 40);
    endtask
endmodule
`default_nettype wire

// >>> brpp_port_tb_top.sv
// Self-checking bench for the remote digit-pair programming port.
`timescale 1ns/1ps
`default_nettype none
module brpp_port_tb_top
    import brpp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // APB side.
    logic [7:0]  paddr;                    // APB byte address.
    logic [31:0] pwdata, prdata, d;        // APB data and the last word taken.
    logic        stb_n, rrst_n, lr_n, flag_n, irq, err; // Remote lines and flags.
    logic [3:0]  g1_n, g2_n;               // Digit lines from the controller model.
    logic [39:0] v, e;                     // Forty-bit value seen and expected.
    int          num_errors, checked, hold, i; // Counters and strobe length.
    logic [3:0]  types [5] = '{TYPE_PM, TYPE_FM_A, TYPE_FM_B, TYPE_FM_C, TYPE_AM};
    logic [3:0]  srcs  [5] = '{SRC_EXT_AC, SRC_EXT_DC, SRC_I400, SRC_I1K, SRC_I1K};
    logic [5:0]  dec   [5] = '{{BRPP_MT_PM, BRPP_MS_EXTAC}, {BRPP_MT_FM1, BRPP_MS_EXTDC},
                               {BRPP_MT_FM2, BRPP_MS_I400}, {BRPP_MT_FM3, BRPP_MS_I1K},
                               {BRPP_MT_AM, BRPP_MS_I1K}};

    // Clock of 100 ns period.
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    brpp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_strobe_n(stb_n),
        .digit_group_one_n(g1_n), .digit_group_two_n(g2_n), .remote_reset_n(rrst_n),
        .local_remote_select_n(lr_n), .flag_n(flag_n), .irq(irq));

    brpp_ctl_model ctl (.pclk(pclk), .flag_n(flag_n), .cmd_strobe_n(stb_n),
        .digit_group_one_n(g1_n), .digit_group_two_n(g2_n));

    // Compares one value and counts the outcome.
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Counts: %0d mismatches, %0d comparisons", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
        d   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a forty-bit register as its low and high words.
    task automatic rd40(input logic [7:0] a);
        apb(1'b0, a, '0);
        v[31:0] = d;
        apb(1'b0, a + 8'h04, '0);
        v[39:32] = d[7:0];
    endtask

    // One strobe; a remote strobe must be acknowledged by the flag.
    task automatic pair(input logic [3:0] a, input logic [3:0] b);
        logic ok;
        ctl.send(a, b, hold, ok);
        if (lr_n === 1'b0) check({39'h0, ok}, 40'h1);
    endtask

    // Address pair, then the strobe that performs the transfer.
    task automatic xfer(input logic [3:0] adr);
        pair(ADDR_MARK, adr);
        pair(4'h0, 4'h0);
    endtask

    // Watchdog, far beyond the roughly one thousand cycles the tests take.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
    end

    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        rrst_n = 1'b1;
        lr_n = 1'b0;
        hold = 2;
        num_errors = 0;
        checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({39'h0, flag_n}, 40'h1);
        check({39'h0, irq}, 40'h0);
        rd40(OFF_TEMP_LO);
        check(v, TEMP_RST);
        apb(1'b0, OFF_MASK, '0);
        check({8'h0, d}, {32'h0, MASK_RST});
        // Four pairs, then a transfer to the centre frequency register.
        e = '0;
        for (i = 1; i <= 7; i += 2) begin
            pair(4'(i), 4'((i + 1) % 8));
            e = {4'((i + 1) % 8), 4'(i), e[39:8]};
        end
        rd40(OFF_TEMP_LO);
        check(v, e);
        xfer(ADR_CF);
        rd40(OFF_CF_LO);
        check(v, e);
        rd40(OFF_TEMP_LO);
        check(v, 40'h0);
        // Six slow pairs overflow ten digits into the step register.
        hold = 5;
        for (i = 1; i <= 6; i++) begin
            pair(4'(i), 4'(i));
            e = {4'(i), 4'(i), e[39:8]};
        end
        xfer(ADR_STEP);
        rd40(OFF_STEP_LO);
        check(v, e);
        // Attenuator keeps only its three leading digits.
        pair(4'h2, 4'h1);
        xfer(ADR_ATTEN);
        apb(1'b0, OFF_ATTEN, '0);
        check({8'h0, d}, 40'h120);
        pair(4'h0, 4'h7);
        pair(4'h0, 4'h0);
        xfer(ADR_ATTEN);
        apb(1'b0, OFF_ATTEN, '0);
        check({8'h0, d}, 40'h007);
        hold = 2;
        // Percent and function registers load independently.
        pair(4'h3, 4'h0);
        xfer(ADR_MODPCT);
        pair(SRC_I1K, TYPE_AM);
        xfer(ADR_MODFN);
        apb(1'b0, OFF_MODFN, '0);
        check({8'h0, d}, 40'h81);
        apb(1'b0, OFF_MODPCT, '0);
        check({8'h0, d}, 40'h00_0300_0000);
        for (i = 0; i < 5; i++) begin
            pair(srcs[i], types[i]);
            xfer(ADR_MODFN);
            apb(1'b0, OFF_STATUS, '0);
            check({34'h0, d[14:9]}, {34'h0, dec[i]});
        end
        // A transfer of empty contents switches modulation off.
        xfer(ADR_MODFN);
        apb(1'b0, OFF_MODFN, '0);
        check({8'h0, d}, 40'h0);
        apb(1'b0, OFF_STATUS, '0);
        check({34'h0, d[14:9]}, {34'h0, BRPP_MT_OFF, BRPP_MS_NONE});
        // An unknown address leaves storage alone but empties the temporary.
        apb(1'b0, OFF_IRQ, '0);
        pair(4'h9, 4'h9);
        xfer(4'h6);
        rd40(OFF_CF_LO);
        check(v, 40'h07_6543_2100);
        apb(1'b0, OFF_ATTEN, '0);
        check({8'h0, d}, 40'h007);
        rd40(OFF_TEMP_LO);
        check(v, 40'h0);
        apb(1'b0, OFF_IRQ, '0);
        check({39'h0, d[IRQ_BADAD]}, 40'h1);
        // Interrupt: masked, unmasked, then cleared by the read.
        pair(4'h1, 4'h1);
        @(negedge pclk);
        check({39'h0, irq}, 40'h0);
        apb(1'b1, OFF_MASK, 32'h1);
        @(negedge pclk);
        check({39'h0, irq}, 40'h1);
        apb(1'b0, OFF_IRQ, '0);
        check({36'h0, d[3:0]}, 40'h1);
        @(negedge pclk);
        check({39'h0, irq}, 40'h0);
        // Software clear, then a strobe in local mode that must be ignored.
        apb(1'b1, OFF_CTRL, 32'h1);
        rd40(OFF_TEMP_LO);
        check(v, 40'h0);
        lr_n <= 1'b1;
        pair(4'h2, 4'h2);
        rd40(OFF_TEMP_LO);
        check(v, 40'h0);
        lr_n <= 1'b0;
        // Remote reset of the shortest accepted length.
        pair(SRC_I1K, TYPE_AM);
        xfer(ADR_MODFN);
        pair(4'h4, 4'h4);
        @(posedge pclk);
        rrst_n <= 1'b0;
        repeat (RST_CYC) @(posedge pclk);
        rrst_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rd40(OFF_TEMP_LO);
        check(v, 40'h0);
        apb(1'b0, OFF_MODFN, '0);
        check({8'h0, d}, 40'h0);
        apb(1'b0, OFF_IRQ, '0);
        check({39'h0, d[IRQ_RRST]}, 40'h1);
        // Unmapped address answers with an error and zero data.
        apb(1'b0, 8'h3c, '0);
        check({7'h0, err, d}, 40'h01_0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
